// File: pkg/cmp_skip_branch_pkg.sv
package cmp_skip_branch_pkg;

  localparam int DATA_W     = 8;
  localparam int BYTE_MSB   = 7;
  localparam int NIBBLE_MSB = 3;
  localparam int BIT_SEL_W  = 3;

  // Bit positions inside the status_flags_register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  // Program counter steps, in instruction words.
  localparam int SEQ_STEP       = 1;
  localparam int SKIP_STEP_ONE  = 2;
  localparam int SKIP_STEP_TWO  = 3;
  localparam int BRANCH_BIAS    = 1;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_COMPARE,
    OP_COMPARE_CARRY,
    OP_COMPARE_IMM,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_EQUAL,
    OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_SAME_OR_HIGHER,
    OP_BRANCH_LOWER,
    OP_BRANCH_MINUS,
    OP_BRANCH_PLUS,
    OP_BRANCH_GREATER_EQUAL_SIGNED,
    OP_BRANCH_LESS_SIGNED
  } exec_op_t;

endpackage : cmp_skip_branch_pkg

// File: verilog/cmp_flag_calc.sv
`timescale 1ns/100ps
module cmp_flag_calc (
  input  wire logic [7:0] minuend,
  input  wire logic [7:0] subtrahend,
  input  wire logic       borrow_in,
  input  wire logic       chain_zero,
  input  wire logic       zero_in,
  output logic            flag_c,
  output logic            flag_z,
  output logic            flag_n,
  output logic            flag_v,
  output logic            flag_s,
  output logic            flag_h
);

  localparam int MSB = cmp_skip_branch_pkg::BYTE_MSB;
  localparam int NSB = cmp_skip_branch_pkg::NIBBLE_MSB;

  logic [8:0] diff;
  logic [4:0] nib_diff;

  assign diff     = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
  assign nib_diff = {1'b0, minuend[NSB:0]} - {1'b0, subtrahend[NSB:0]} - {4'h0, borrow_in};

  assign flag_c = diff[MSB+1];
  assign flag_h = nib_diff[NSB+1];
  assign flag_n = diff[MSB];
  assign flag_v = (minuend[MSB] ^ subtrahend[MSB]) & (minuend[MSB] ^ diff[MSB]);
  assign flag_s = flag_n ^ flag_v;
  // A chained compare only keeps zero when every earlier byte was also equal.
  assign flag_z = (diff[MSB:0] == 8'h00) & (chain_zero ? zero_in : 1'b1);

endmodule : cmp_flag_calc

// File: verilog/branch_cond_eval.sv
`timescale 1ns/100ps
module branch_cond_eval (
  input  wire cmp_skip_branch_pkg::exec_op_t op,
  input  wire logic [2:0]                    bit_sel,
  input  wire logic [7:0]                    status,
  output logic                               is_branch,
  output logic                               take
);

  logic       want_one;
  logic       use_signed;
  logic [2:0] sel;
  logic       cond_bit;

  always_comb begin
    is_branch  = 1'b1;
    want_one   = 1'b1;
    use_signed = 1'b0;
    sel        = 3'(cmp_skip_branch_pkg::FLAG_Z);
    case (op)
      cmp_skip_branch_pkg::OP_BRANCH_FLAG_SET: begin
        sel = bit_sel;
      end
      cmp_skip_branch_pkg::OP_BRANCH_FLAG_CLEAR: begin
        sel      = bit_sel;
        want_one = 1'b0;
      end
      cmp_skip_branch_pkg::OP_BRANCH_EQUAL: begin
        sel = 3'(cmp_skip_branch_pkg::FLAG_Z);
      end
      cmp_skip_branch_pkg::OP_BRANCH_NOT_EQUAL: begin
        sel      = 3'(cmp_skip_branch_pkg::FLAG_Z);
        want_one = 1'b0;
      end
      cmp_skip_branch_pkg::OP_BRANCH_CARRY_SET,
      cmp_skip_branch_pkg::OP_BRANCH_LOWER: begin
        sel = 3'(cmp_skip_branch_pkg::FLAG_C);
      end
      cmp_skip_branch_pkg::OP_BRANCH_CARRY_CLEAR,
      cmp_skip_branch_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
        sel      = 3'(cmp_skip_branch_pkg::FLAG_C);
        want_one = 1'b0;
      end
      cmp_skip_branch_pkg::OP_BRANCH_MINUS: begin
        sel = 3'(cmp_skip_branch_pkg::FLAG_N);
      end
      cmp_skip_branch_pkg::OP_BRANCH_PLUS: begin
        sel      = 3'(cmp_skip_branch_pkg::FLAG_N);
        want_one = 1'b0;
      end
      cmp_skip_branch_pkg::OP_BRANCH_GREATER_EQUAL_SIGNED: begin
        use_signed = 1'b1;
        want_one   = 1'b0;
      end
      cmp_skip_branch_pkg::OP_BRANCH_LESS_SIGNED: begin
        use_signed = 1'b1;
      end
      default: begin
        is_branch = 1'b0;
      end
    endcase
  end

  // Signed order comes from negative xor overflow, so a stale sign flag cannot mislead it.
  assign cond_bit = use_signed ? (status[cmp_skip_branch_pkg::FLAG_N] ^
                                  status[cmp_skip_branch_pkg::FLAG_V]) : status[sel];
  assign take     = is_branch & (cond_bit == want_one);

endmodule : branch_cond_eval

// File: verilog/compare_skip_branch_exec.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Plain compare subtracts source from destination register, flags only.
// - Compare with carry subtracts source and carry from destination, flags only.
// - Compare immediate subtracts the instruction constant from destination, flags only.
// - Compares update Z, N, V, S, C, H; skips and branches change no flag.
// - Skip when the chosen working register bit is clear, stepping two or three.
// - Skip when the chosen working register bit is set, stepping two or three.
// - Skip when the chosen I/O register bit is clear, stepping two or three.
// - Skip when the chosen I/O register bit is set, stepping two or three.
// - Branch on chosen status bit set: PC becomes PC plus offset plus one.
// - Branch on chosen status bit clear: PC becomes PC plus offset plus one.
// - Branch when the last compare found operands unequal, else continue.
// - Branch when carry is one, else continue.
// - Branch when carry is zero, else continue.
// - Unsigned same-or-higher branch taken when carry is zero.
// - Unsigned lower branch taken when carry is one.
// - Branch when negative flag is one.
// - Branch when negative flag is zero.
// - Signed greater-or-equal branch taken when destination not below source.
// - Signed less-than branch taken when destination below source.
module compare_skip_branch_exec #(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          req_valid,
  input  wire cmp_skip_branch_pkg::exec_op_t req_op,
  input  wire logic [PC_W-1:0]               req_pc,
  input  wire logic [7:0]                    req_dst_val,
  input  wire logic [7:0]                    src_work_reg,
  input  wire logic [7:0]                    req_imm,
  input  wire logic [7:0]                    req_io_val,
  input  wire logic [2:0]                    req_bit_sel,
  input  wire logic [OFS_W-1:0]              req_offset,
  input  wire logic [7:0]                    status_in,
  input  wire logic                          next_len_valid,
  input  wire logic                          next_two_word,
  output logic                               ready_q,
  output logic                               done_q,
  output logic [PC_W-1:0]                    pc_q,
  output logic                               pc_jump_q,
  output logic                               skip_taken_q,
  output logic                               branch_taken_q,
  output logic [7:0]                         status_q,
  output logic                               status_we_q
);

  if (PC_W < 2 || PC_W > 32) begin : g_bad_pc_width
    $error("PC_W must lie between 2 and 32");
  end
  if (OFS_W < 1 || OFS_W >= PC_W) begin : g_bad_offset_width
    $error("OFS_W must be at least 1 and below PC_W");
  end

  typedef enum logic [0:0] {
    ST_READY,
    ST_WAIT_LEN
  } exec_state_t;

  localparam logic [PC_W-1:0] STEP_SEQ  = PC_W'(cmp_skip_branch_pkg::SEQ_STEP);
  localparam logic [PC_W-1:0] STEP_ONE  = PC_W'(cmp_skip_branch_pkg::SKIP_STEP_ONE);
  localparam logic [PC_W-1:0] STEP_TWO  = PC_W'(cmp_skip_branch_pkg::SKIP_STEP_TWO);
  localparam logic [PC_W-1:0] BR_BIAS   = PC_W'(cmp_skip_branch_pkg::BRANCH_BIAS);
  localparam logic [PC_W-1:0] PC_RESET  = '0;

  exec_state_t       state_q;
  exec_state_t       state_d;
  logic [PC_W-1:0]   pend_pc_q;

  logic              accept;
  logic [7:0]        status_eff;
  logic              is_cmp;
  logic              is_skip;
  logic              skip_reg;
  logic              skip_on_set;
  logic              test_bit;
  logic              skip_hit;
  logic [7:0]        subtrahend;
  logic              borrow_in;
  logic              chain;
  logic              f_c;
  logic              f_z;
  logic              f_n;
  logic              f_v;
  logic              f_s;
  logic              f_h;
  logic [7:0]        cmp_status;
  logic              is_branch;
  logic              br_take;
  logic [PC_W-1:0]   offset_ext;
  logic [PC_W-1:0]   pc_seq;
  logic [PC_W-1:0]   pc_branch;
  logic [PC_W-1:0]   pc_skip_now;
  logic [PC_W-1:0]   pc_skip_late;
  logic              skip_waits;

  assign accept = req_valid & ready_q;

  // The outer status register only catches the written flags after done_q,
  // so a dependent instruction accepted in that cycle reads the fresh copy.
  assign status_eff = status_we_q ? status_q : status_in;

  // Compare operand selection.
  always_comb begin
    is_cmp     = 1'b1;
    subtrahend = src_work_reg;
    borrow_in  = 1'b0;
    chain      = 1'b0;
    case (req_op)
      cmp_skip_branch_pkg::OP_COMPARE: begin
        subtrahend = src_work_reg;
      end
      cmp_skip_branch_pkg::OP_COMPARE_CARRY: begin
        subtrahend = src_work_reg;
        borrow_in  = status_eff[cmp_skip_branch_pkg::FLAG_C];
        chain      = 1'b1;
      end
      cmp_skip_branch_pkg::OP_COMPARE_IMM: begin
        subtrahend = req_imm;
      end
      default: begin
        is_cmp = 1'b0;
      end
    endcase
  end

  cmp_flag_calc u_flags (
    .minuend    (req_dst_val),
    .subtrahend (subtrahend),
    .borrow_in  (borrow_in),
    .chain_zero (chain),
    .zero_in    (status_eff[cmp_skip_branch_pkg::FLAG_Z]),
    .flag_c     (f_c),
    .flag_z     (f_z),
    .flag_n     (f_n),
    .flag_v     (f_v),
    .flag_s     (f_s),
    .flag_h     (f_h)
  );

  // The difference itself goes nowhere; only the flags leave this block.
  always_comb begin
    cmp_status                              = status_eff;
    cmp_status[cmp_skip_branch_pkg::FLAG_C] = f_c;
    cmp_status[cmp_skip_branch_pkg::FLAG_Z] = f_z;
    cmp_status[cmp_skip_branch_pkg::FLAG_N] = f_n;
    cmp_status[cmp_skip_branch_pkg::FLAG_V] = f_v;
    cmp_status[cmp_skip_branch_pkg::FLAG_S] = f_s;
    cmp_status[cmp_skip_branch_pkg::FLAG_H] = f_h;
  end

  // Skip selection.
  always_comb begin
    is_skip     = 1'b1;
    skip_reg    = 1'b1;
    skip_on_set = 1'b0;
    case (req_op)
      cmp_skip_branch_pkg::OP_SKIP_REG_BIT_CLEAR: begin
        skip_reg = 1'b1;
      end
      cmp_skip_branch_pkg::OP_SKIP_REG_BIT_SET: begin
        skip_on_set = 1'b1;
      end
      cmp_skip_branch_pkg::OP_SKIP_IO_BIT_CLEAR: begin
        skip_reg = 1'b0;
      end
      cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET: begin
        skip_reg    = 1'b0;
        skip_on_set = 1'b1;
      end
      default: begin
        is_skip = 1'b0;
      end
    endcase
  end

  assign test_bit   = skip_reg ? src_work_reg[req_bit_sel] : req_io_val[req_bit_sel];
  assign skip_hit   = is_skip & (test_bit == skip_on_set);
  // A hit must know whether the instruction it jumps over is one or two words.
  assign skip_waits = skip_hit & ~next_len_valid;

  branch_cond_eval u_cond (
    .op        (req_op),
    .bit_sel   (req_bit_sel),
    .status    (status_eff),
    .is_branch (is_branch),
    .take      (br_take)
  );

  assign offset_ext   = {{(PC_W-OFS_W){req_offset[OFS_W-1]}}, req_offset};
  assign pc_seq       = req_pc + STEP_SEQ;
  assign pc_branch    = req_pc + offset_ext + BR_BIAS;
  assign pc_skip_now  = req_pc + (next_two_word ? STEP_TWO : STEP_ONE);
  assign pc_skip_late = pend_pc_q + (next_two_word ? STEP_TWO : STEP_ONE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_READY: begin
        if (accept && skip_waits) begin
          state_d = ST_WAIT_LEN;
        end
      end
      ST_WAIT_LEN: begin
        if (next_len_valid) begin
          state_d = ST_READY;
        end
      end
      default: begin
        state_d = ST_READY;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= ST_READY;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == ST_READY);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_pc_q <= PC_RESET;
    end else if (accept && skip_waits) begin
      pend_pc_q <= req_pc;
    end
  end

  // Program counter answer, one cycle after the request or the late length.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q         <= 1'b0;
      pc_q           <= PC_RESET;
      pc_jump_q      <= 1'b0;
      skip_taken_q   <= 1'b0;
      branch_taken_q <= 1'b0;
    end else if (state_q == ST_WAIT_LEN) begin
      done_q         <= next_len_valid;
      skip_taken_q   <= next_len_valid;
      pc_jump_q      <= next_len_valid;
      branch_taken_q <= 1'b0;
      if (next_len_valid) begin
        pc_q <= pc_skip_late;
      end
    end else begin
      done_q         <= accept & ~skip_waits;
      skip_taken_q   <= accept & skip_hit & ~skip_waits;
      branch_taken_q <= accept & br_take;
      pc_jump_q      <= accept & ((skip_hit & ~skip_waits) | br_take);
      // A skip that still waits for the next length keeps pc_q until its late answer.
      if (accept && !skip_waits) begin
        if (skip_hit) begin
          pc_q <= pc_skip_now;
        end else if (br_take) begin
          pc_q <= pc_branch;
        end else begin
          pc_q <= pc_seq;
        end
      end
    end
  end

  // Skips and branches never raise the write strobe, so the flags stay as they were.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q    <= cmp_skip_branch_pkg::STATUS_RESET;
      status_we_q <= 1'b0;
    end else begin
      status_we_q <= accept & is_cmp;
      if (accept && is_cmp) begin
        status_q <= cmp_status;
      end
    end
  end

endmodule : compare_skip_branch_exec

// File: bench/compare_skip_branch_exec_chk.sv
`timescale 1ns/100ps
module compare_skip_branch_exec_chk #(
  parameter int PC_W  = 16,
  parameter int OFS_W = 7
) (
  input wire logic                          clk_sys,
  input wire logic                          rst,
  input wire logic                          req_valid,
  input wire cmp_skip_branch_pkg::exec_op_t req_op,
  input wire logic [PC_W-1:0]               req_pc,
  input wire logic [OFS_W-1:0]              req_offset,
  input wire logic                          next_len_valid,
  input wire logic                          next_two_word,
  input wire logic                          ready_q,
  input wire logic                          done_q,
  input wire logic [PC_W-1:0]               pc_q,
  input wire logic                          pc_jump_q,
  input wire logic                          skip_taken_q,
  input wire logic                          branch_taken_q,
  input wire logic [7:0]                    status_q,
  input wire logic                          status_we_q
);
  logic            acc;
  logic            is_cmp;
  logic            is_skip;
  logic            is_br;
  logic [PC_W-1:0] ofs_ext;

  assign acc = req_valid && ready_q;
  assign is_cmp = req_op >= cmp_skip_branch_pkg::OP_COMPARE
               && req_op <= cmp_skip_branch_pkg::OP_COMPARE_IMM;
  assign is_skip = req_op >= cmp_skip_branch_pkg::OP_SKIP_REG_BIT_CLEAR
                && req_op <= cmp_skip_branch_pkg::OP_SKIP_IO_BIT_SET;
  assign is_br = req_op >= cmp_skip_branch_pkg::OP_BRANCH_FLAG_SET;
  assign ofs_ext = PC_W'($signed(req_offset));

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_we_with_done: assert property (status_we_q |-> done_q && !pc_jump_q)
    else $error("status write without a plain answer");
  chk_jump_has_cause: assert property (pc_jump_q |-> done_q && (skip_taken_q ^ branch_taken_q))
    else $error("jump without exactly one cause");
  chk_status_holds: assert property (!status_we_q && !$past(rst) |-> $stable(status_q))
    else $error("status changed without a compare");
  chk_pc_holds: assert property (!done_q && !$past(rst) |-> $stable(pc_q))
    else $error("pc changed between answers");
  chk_cmp_answer: assert property (acc && is_cmp |=> done_q && status_we_q
    && pc_q == $past(req_pc) + 1'b1) else $error("compare answer wrong");
  chk_noncmp_no_we: assert property (acc && !is_cmp |=> !status_we_q)
    else $error("status written by a skip or branch");
  chk_branch_target: assert property (acc && is_br |=> done_q && !skip_taken_q
    && pc_q == $past(req_pc) + (branch_taken_q ? $past(ofs_ext) + 1'b1 : 1'b1))
    else $error("branch target wrong");
  chk_skip_step: assert property (acc && is_skip && next_len_valid |=> done_q
    && pc_q == $past(req_pc) + (skip_taken_q ? ($past(next_two_word) ? 16'h3 : 16'h2) : 16'h1))
    else $error("skip step wrong");
  chk_skip_waits: assert property (acc && is_skip && !next_len_valid
    |=> !(done_q && skip_taken_q)) else $error("skip taken before length known");
endmodule : compare_skip_branch_exec_chk

bind compare_skip_branch_exec compare_skip_branch_exec_chk #(.PC_W(PC_W), .OFS_W(OFS_W)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_pc(req_pc),
  .req_offset(req_offset), .next_len_valid(next_len_valid), .next_two_word(next_two_word),
  .ready_q(ready_q), .done_q(done_q), .pc_q(pc_q), .pc_jump_q(pc_jump_q),
  .skip_taken_q(skip_taken_q), .branch_taken_q(branch_taken_q), .status_q(status_q),
  .status_we_q(status_we_q)
);

// File: bench/compare_skip_branch_exec_test.sv
`timescale 1ns/100ps
module compare_skip_branch_exec_test;
  logic                          clk_sys = 1'b0;
  logic                          rst = 1'b1;
  logic                          req_valid = 1'b0;
  cmp_skip_branch_pkg::exec_op_t req_op = cmp_skip_branch_pkg::OP_NONE;
  logic [15:0]                   req_pc = 16'h1000;
  logic [7:0]                    req_dst_val = 8'h00;
  logic [7:0]                    src_work_reg = 8'h00;
  logic [7:0]                    req_imm = 8'h00;
  logic [7:0]                    req_io_val = 8'h00;
  logic [7:0]                    status_in = 8'h00;
  logic [2:0]                    req_bit_sel = 3'h0;
  logic [6:0]                    req_offset = 7'h00;
  logic                          next_len_valid = 1'b1;
  logic                          next_two_word = 1'b0;
  logic                          ready_q, done_q, pc_jump_q, skip_taken_q;
  logic                          branch_taken_q, status_we_q;
  logic [15:0]                   pc_q;
  logic [7:0]                    status_q;
  int                            errors = 0;
  int                            compares = 0;

  always #5 clk_sys = ~clk_sys;

  compare_skip_branch_exec #(.PC_W(16), .OFS_W(7)) dut (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_pc(req_pc),
    .req_dst_val(req_dst_val), .src_work_reg(src_work_reg), .req_imm(req_imm),
    .req_io_val(req_io_val), .req_bit_sel(req_bit_sel), .req_offset(req_offset),
    .status_in(status_in), .next_len_valid(next_len_valid), .next_two_word(next_two_word),
    .ready_q(ready_q), .done_q(done_q), .pc_q(pc_q), .pc_jump_q(pc_jump_q),
    .skip_taken_q(skip_taken_q), .branch_taken_q(branch_taken_q), .status_q(status_q),
    .status_we_q(status_we_q)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  // One idle cycle first, so status_q forwarding never applies here.
  task automatic issue(input int late);
    int n;
    n = 0;
    @(posedge clk_sys);
    #1;
    while (ready_q !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(ready_q, 1'b1);
    req_valid = 1'b1;
    next_len_valid = (late == 0);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    repeat (late) begin
      check(done_q, 1'b0);
      check(ready_q, 1'b0);
      @(posedge clk_sys);
      #1;
    end
    if (late > 0) begin
      next_len_valid = 1'b1;
      @(posedge clk_sys);
      #1;
    end
    check(done_q, 1'b1);
  endtask : issue

  // Flag bits: C0 Z1 N2 V3 S4 H5; T and I pass through.
  function automatic logic [7:0] cmp_ref(input logic [7:0] d, s, st, input logic wc);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] o;
    r = {1'b0, d} - {1'b0, s} - 9'(wc & st[0]);
    h = {1'b0, d[3:0]} - {1'b0, s[3:0]} - 5'(wc & st[0]);
    o = st;
    o[0] = r[8];
    o[1] = (r[7:0] == 8'h00) && (!wc || st[1]);
    o[2] = r[7];
    o[3] = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
    o[4] = o[2] ^ o[3];
    o[5] = h[4];
    return o;
  endfunction : cmp_ref

  function automatic logic bref(input cmp_skip_branch_pkg::exec_op_t op, input logic [2:0] b,
                                input logic [7:0] s);
    case (int'(op))
      8: return s[b];
      9: return !s[b];
      10: return s[1];
      11: return !s[1];
      12, 15: return s[0];
      13, 14: return !s[0];
      16: return s[2];
      17: return !s[2];
      18: return !(s[2] ^ s[3]);
      default: return s[2] ^ s[3];
    endcase
  endfunction : bref

  task automatic t_compare();
    logic [7:0] d[6] = '{8'h05, 8'h05, 8'h80, 8'h10, 8'h06, 8'h06};
    logic [7:0] s[6] = '{8'h05, 8'h06, 8'h01, 8'h01, 8'h05, 8'h05};
    logic [7:0] v;
    for (int i = 0; i < 18; i++) begin
      req_op = cmp_skip_branch_pkg::exec_op_t'(1 + i % 3);
      req_dst_val = d[i/3];
      v = (i % 3 == 2) ? ~s[i/3] : s[i/3];
      src_work_reg = v;
      req_imm = ~v;
      status_in = i[0] ? 8'h43 : 8'h01;
      issue(0);
      check(status_q, cmp_ref(d[i/3], s[i/3], status_in, i % 3 == 1));
      check(status_we_q, 1'b1);
      check(pc_q, req_pc + 16'h1);
      check(pc_jump_q, 1'b0);
    end
    $display("compare test done");
  endtask : t_compare

  task automatic t_skip();
    logic [7:0] pat;
    logic       tk;
    for (int i = 0; i < 16; i++) begin
      req_op = cmp_skip_branch_pkg::exec_op_t'(4 + i % 4);
      req_bit_sel = 3'(i * 3);
      next_two_word = i[3];
      pat = i[2] ? (8'h01 << req_bit_sel) : ~(8'h01 << req_bit_sel);
      src_work_reg = i[1] ? ~pat : pat;
      req_io_val = i[1] ? pat : ~pat;
      tk = (i[0] == i[2]);
      issue((i == 5 || i == 10) ? 3 : 0);
      check(skip_taken_q, tk);
      check(pc_q, req_pc + (tk ? (i[3] ? 16'h3 : 16'h2) : 16'h1));
      check(branch_taken_q, 1'b0);
      check(pc_jump_q, tk);
      check(status_we_q, 1'b0);
    end
    $display("skip test done");
  endtask : t_skip

  task automatic t_branch();
    logic [7:0] st[4] = '{8'h00, 8'hFF, 8'h05, 8'h0A};
    logic       tk;
    for (int i = 0; i < 48; i++) begin
      req_op = cmp_skip_branch_pkg::exec_op_t'(8 + i % 12);
      status_in = st[i/12];
      req_bit_sel = 3'(i * 5);
      req_offset = i[0] ? 7'h40 : 7'h3F;
      issue(0);
      tk = bref(req_op, req_bit_sel, status_in);
      check(branch_taken_q, tk);
      check(pc_jump_q, tk);
      check(pc_q, req_pc + 16'h1 + (tk ? {{9{req_offset[6]}}, req_offset} : 16'h0));
      check(status_we_q, 1'b0);
    end
    $display("branch test done");
  endtask : t_branch

  // The branch is accepted in the cycle where the compare answers, so it must see status_q.
  task automatic t_back_to_back();
    @(posedge clk_sys);
    #1;
    req_op = cmp_skip_branch_pkg::OP_COMPARE;
    req_dst_val = 8'h33;
    src_work_reg = 8'h33;
    status_in = 8'h00;
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    req_op = cmp_skip_branch_pkg::OP_BRANCH_NOT_EQUAL;
    req_offset = 7'h02;
    check(status_we_q, 1'b1);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    check(done_q, 1'b1);
    check(branch_taken_q, 1'b0);
    check(pc_q, req_pc + 16'h1);
    req_op = cmp_skip_branch_pkg::OP_NONE;
    issue(0);
    check(pc_q, req_pc + 16'h1);
    check(pc_jump_q, 1'b0);
    check(status_we_q, 1'b0);
    $display("back to back test done");
  endtask : t_back_to_back

  initial begin
    #20000;
    errors++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    check(ready_q, 1'b0);
    check(pc_q, 16'h0);
    check(status_q, 8'h00);
    rst = 1'b0;
    t_compare();
    t_skip();
    t_branch();
    t_back_to_back();
    complete_run();
  end
endmodule : compare_skip_branch_exec_test
